// ===== rtl/gpio_port_lcd_share.v
// Purpose: port direction, data, pull-up and port 2 lcd/io sharing registers
// Assumes: classic wishbone slave, one clock, inputs synchronous to clk
// Notes:   every output registered; ack answers one cycle after the request
//          bit operations at a spare index change one pin at a time
`timescale 1ns/1ps
`include "gpio_port_lcd_share_defines.vh"

// Overview of operation
// [RULE1] direction bit 0 makes pin input, 1 makes pin output
// [RULE2] every bidirectional pin has its own direction bit
// [RULE3] single direction bits can be set or cleared without touching others
// [RULE4] pull-up bits are write-only, 1 enables pull-up, cleared at reset
// [RULE5] reading a data register returns current pin input levels
// [RULE6] byte or single-bit data writes set levels driven on output pins
// [RULE7] upper select 0: seg 20-23 lcd; 1: p2.0-p2.3 io, first bias to vdd
// [RULE8] lower select 0: seg 24-27 lcd, second bias to supply; 1: p2.4-p2.7 io
// [RULE9] blank bit 1 turns all lcd dots off, 0 normal display
// [RULE10] lcd enable bit 0 disables lcd driver, 1 enables it
// [RULE11] data written while input is latched and driven once pin turns output
// [RULE12] reset: all inputs, pull-ups off, lcd off, both groups lcd
module gpio_port_lcd_share (
    input  wire        clk,          // cpu clock
    input  wire        rst_b,        // async reset, active low
    input  wire        wb_cyc_i,     // bus cycle
    input  wire        wb_stb_i,     // strobe
    input  wire        wb_we_i,      // write enable
    input  wire [9:0]  wb_adr_i,     // byte address
    input  wire [3:0]  wb_sel_i,     // byte lanes
    input  wire [31:0] wb_dat_i,     // write data
    output reg  [31:0] wb_dat_o,     // read data
    output reg         wb_ack_o,     // acknowledge
    input  wire [1:0]  p0In,         // port 0 pin levels (input only)
    input  wire [7:0]  p1In,         // port 1 pin levels
    input  wire [7:0]  p2In,         // port 2 pin levels
    input  wire [7:0]  p5In,         // port 5 pin levels
    output reg  [7:0]  p1Out,        // port 1 drive level
    output reg  [7:0]  p1Oe,         // port 1 output enable
    output reg  [7:0]  p2Out,        // port 2 drive level
    output reg  [7:0]  p2Oe,         // port 2 output enable
    output reg  [7:0]  p5Out,        // port 5 drive level
    output reg  [7:0]  p5Oe,         // port 5 output enable
    output reg  [1:0]  p0PullEn,     // port 0 pull-up enables
    output reg  [7:0]  p1PullEn,     // port 1 pull-up enables
    output reg  [7:0]  p2PullEn,     // port 2 pull-up enables
    output reg  [7:0]  p5PullEn,     // port 5 pull-up enables
    output reg  [7:0]  lcdSegEn,     // segment 20..27 lcd enables
    output reg         lcdDriverOn,  // lcd driver enabled
    output reg         lcdBlankAll,  // all lcd dots off
    output reg         firstBiasVdd, // first bias node tied to vdd
    output reg         secondBiasLcd // second bias node tied to lcd supply
);

    // software-visible registers
    reg  [7:0] lcdCtrl_reg;
    reg  [7:0] p1Dir_reg;
    reg  [7:0] p2Dir_reg;
    reg  [7:0] p5Dir_reg;
    reg  [1:0] p0Latch_reg;
    reg  [7:0] p1Latch_reg;
    reg  [7:0] p2Latch_reg;
    reg  [7:0] p5Latch_reg;
    reg  [1:0] p0Pull_reg;
    reg  [7:0] p1Pull_reg;
    reg  [7:0] p2Pull_reg;
    reg  [7:0] p5Pull_reg;
    reg  [7:0] rdData;
    reg  [7:0] bitMask;

    // next values of the registers, worked out below
    reg  [7:0] lcdCtrl_next;
    reg  [7:0] p1Dir_next;
    reg  [7:0] p2Dir_next;
    reg  [7:0] p5Dir_next;
    reg  [1:0] p0Latch_next;
    reg  [7:0] p1Latch_next;
    reg  [7:0] p2Latch_next;
    reg  [7:0] p5Latch_next;
    reg  [1:0] p0Pull_next;
    reg  [7:0] p1Pull_next;
    reg  [7:0] p2Pull_next;
    reg  [7:0] p5Pull_next;

    // lcd control fields as held in the register
    wire       upperIo  = lcdCtrl_reg[`LCD_UPPER_SEL_BIT];
    wire       lowerIo  = lcdCtrl_reg[`LCD_LOWER_SEL_BIT];
    wire       lcdOn    = lcdCtrl_reg[`LCD_ENABLE_BIT];
    wire       blankAll = lcdCtrl_reg[`LCD_BLANK_BIT];
    // per-pin io use of port 2, set by the group selects
    wire [7:0] p2IoGrp;

    // bus decode; a request counts once, while ack is still low
    wire       req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire       wrEn   = req & wb_we_i & wb_sel_i[0];
    wire [7:0] idx    = wb_adr_i[9:2];
    wire [7:0] wByte  = wb_dat_i[7:0];
    wire [2:0] opPort = wByte[`BITOP_PORT_LSB+2:`BITOP_PORT_LSB];
    wire       opSet  = (wByte & `BITOP_SET) != `RST_BYTE;
    wire       opDir  = (wByte & `BITOP_DIR) != `RST_BYTE;
    wire       bitOp  = wrEn && (idx == `IDX_BIT_OP);

    // bit operation targets; other port codes are ignored
    wire       opP1Dir = bitOp &&  opDir && (opPort == 3'h1);
    wire       opP2Dir = bitOp &&  opDir && (opPort == 3'h2);
    wire       opP5Dir = bitOp &&  opDir && (opPort == 3'h5);
    wire       opP1Dat = bitOp && !opDir && (opPort == 3'h1);
    wire       opP2Dat = bitOp && !opDir && (opPort == 3'h2);
    wire       opP5Dat = bitOp && !opDir && (opPort == 3'h5);

    // set or clear the addressed bit of a byte, keep the others
    function [7:0] applyBit;
        input [7:0] cur;
        input       setIt;
        input [7:0] mask;
        begin
            applyBit = setIt ? (cur | mask) : (cur & ~mask);
        end
    endfunction

    // pins 0-3 follow the upper group select, pins 4-7 the lower one
    genvar pinIdx;
    generate
        for (pinIdx = 0; pinIdx < 8; pinIdx = pinIdx + 1) begin : per_pin
            if (pinIdx < 4) begin : upper_grp
                assign p2IoGrp[pinIdx] = upperIo; // RULE7
            end else begin : lower_grp
                assign p2IoGrp[pinIdx] = lowerIo; // RULE8
            end
        end
    endgenerate

    // one-hot mask of the bit addressed by a bit operation
    always @* begin
        bitMask = 8'h01 << wByte[`BITOP_BIT_LSB+2:`BITOP_BIT_LSB];
    end

    // read mux: data reads show pin levels, pull-ups read as zero
    always @* begin
        case (idx)
            `IDX_LCD_CTRL: rdData = lcdCtrl_reg & `LCD_CTRL_MASK;
            `IDX_P1_DIR:   rdData = p1Dir_reg;
            `IDX_P2_DIR:   rdData = p2Dir_reg;
            `IDX_P5_DIR:   rdData = p5Dir_reg;
            `IDX_P0_DATA:  rdData = {6'h00, p0In};  // RULE5
            `IDX_P1_DATA:  rdData = p1In;           // RULE5
            `IDX_P2_DATA:  rdData = p2In;           // RULE5
            `IDX_P5_DATA:  rdData = p5In;           // RULE5
            default:       rdData = `RST_BYTE;      // RULE4
        endcase
    end

    // bus slave: single-cycle ack, unmapped reads return zero
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= req ? {24'h000000, rdData} : 32'h00000000;
        end
    end

    // next-state of the registers: byte writes, then single-bit operations
    always @* begin
        lcdCtrl_next = lcdCtrl_reg;
        p1Dir_next   = p1Dir_reg;
        p2Dir_next   = p2Dir_reg;
        p5Dir_next   = p5Dir_reg;
        p0Latch_next = p0Latch_reg;
        p1Latch_next = p1Latch_reg;
        p2Latch_next = p2Latch_reg;
        p5Latch_next = p5Latch_reg;
        p0Pull_next  = p0Pull_reg;
        p1Pull_next  = p1Pull_reg;
        p2Pull_next  = p2Pull_reg;
        p5Pull_next  = p5Pull_reg;
        // whole-byte writes; the bit-operation index matches no item here
        if (wrEn) begin
            case (idx)
                `IDX_LCD_CTRL:  lcdCtrl_next = wByte & `LCD_CTRL_MASK; // RULE9 RULE10
                `IDX_P1_DIR:    p1Dir_next   = wByte; // RULE2
                `IDX_P2_DIR:    p2Dir_next   = wByte; // RULE2
                `IDX_P5_DIR:    p5Dir_next   = wByte; // RULE2
                `IDX_P0_DATA:   p0Latch_next = wByte[1:0];
                `IDX_P1_DATA:   p1Latch_next = wByte; // RULE6
                `IDX_P2_DATA:   p2Latch_next = wByte; // RULE6
                `IDX_P5_DATA:   p5Latch_next = wByte; // RULE6
                `IDX_P0_PULLUP: p0Pull_next  = wByte[1:0]; // RULE4
                `IDX_P1_PULLUP: p1Pull_next  = wByte; // RULE4
                `IDX_P2_PULLUP: p2Pull_next  = wByte; // RULE4
                `IDX_P5_PULLUP: p5Pull_next  = wByte; // RULE4
                default:        lcdCtrl_next = lcdCtrl_reg;
            endcase
        end
        // direction bits, one pin at a time
        if (opP1Dir) p1Dir_next = applyBit(p1Dir_reg, opSet, bitMask); // RULE3
        if (opP2Dir) p2Dir_next = applyBit(p2Dir_reg, opSet, bitMask); // RULE3
        if (opP5Dir) p5Dir_next = applyBit(p5Dir_reg, opSet, bitMask); // RULE3
        // data latch bits, one pin at a time
        if (opP1Dat) p1Latch_next = applyBit(p1Latch_reg, opSet, bitMask); // RULE6
        if (opP2Dat) p2Latch_next = applyBit(p2Latch_reg, opSet, bitMask); // RULE6
        if (opP5Dat) p5Latch_next = applyBit(p5Latch_reg, opSet, bitMask); // RULE6
    end

    // register state; reset leaves pins input, pull-ups off, lcd off, groups lcd
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            // lcd control and directions
            lcdCtrl_reg <= `RST_BYTE; // RULE12
            p1Dir_reg   <= `RST_BYTE; // RULE12
            p2Dir_reg   <= `RST_BYTE; // RULE12
            p5Dir_reg   <= `RST_BYTE; // RULE12
            // data latches
            p0Latch_reg <= 2'h0;
            p1Latch_reg <= `RST_BYTE;
            p2Latch_reg <= `RST_BYTE;
            p5Latch_reg <= `RST_BYTE;
            // pull-ups
            p0Pull_reg  <= 2'h0;      // RULE4
            p1Pull_reg  <= `RST_BYTE; // RULE4
            p2Pull_reg  <= `RST_BYTE; // RULE4
            p5Pull_reg  <= `RST_BYTE; // RULE4
        end else begin
            // lcd control and directions
            lcdCtrl_reg <= lcdCtrl_next;
            p1Dir_reg   <= p1Dir_next;
            p2Dir_reg   <= p2Dir_next;
            p5Dir_reg   <= p5Dir_next;
            // data latches
            p0Latch_reg <= p0Latch_next;
            p1Latch_reg <= p1Latch_next;
            p2Latch_reg <= p2Latch_next;
            p5Latch_reg <= p5Latch_next;
            // pull-ups
            p0Pull_reg  <= p0Pull_next;
            p1Pull_reg  <= p1Pull_next;
            p2Pull_reg  <= p2Pull_next;
            p5Pull_reg  <= p5Pull_next;
        end
    end

    // pin drive: latch always holds data, enable follows direction, so a
    // value written while input appears once the pin turns output
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            p1Out <= `RST_BYTE;
            p1Oe  <= `RST_BYTE; // RULE12
        end else begin
            p1Out <= p1Latch_reg; // RULE11
            p1Oe  <= p1Dir_reg;   // RULE1
        end
    end

    // port 2: a pin drives only while its group is in io use
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            p2Out <= `RST_BYTE;
            p2Oe  <= `RST_BYTE; // RULE12
        end else begin
            p2Out <= p2Latch_reg;         // RULE11
            p2Oe  <= p2Dir_reg & p2IoGrp; // RULE1 RULE7 RULE8
        end
    end

    // port 5 drive, same scheme as port 1
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            p5Out <= `RST_BYTE;
            p5Oe  <= `RST_BYTE; // RULE12
        end else begin
            p5Out <= p5Latch_reg; // RULE11
            p5Oe  <= p5Dir_reg;   // RULE1
        end
    end

    // pull-up enables; software cannot read them back
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            p0PullEn <= 2'h0;      // RULE12
            p1PullEn <= `RST_BYTE;
            p2PullEn <= `RST_BYTE;
            p5PullEn <= `RST_BYTE;
        end else begin
            p0PullEn <= p0Pull_reg; // RULE4
            p1PullEn <= p1Pull_reg;
            p2PullEn <= p2Pull_reg;
            p5PullEn <= p5Pull_reg;
        end
    end

    // lcd control outputs; the bias nodes follow the group selects
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lcdSegEn      <= 8'hFF; // RULE12
            lcdDriverOn   <= 1'b0;
            lcdBlankAll   <= 1'b0;
            firstBiasVdd  <= 1'b0;
            secondBiasLcd <= 1'b1;
        end else begin
            lcdSegEn      <= ~p2IoGrp; // RULE7 RULE8
            lcdDriverOn   <= lcdOn;    // RULE10
            lcdBlankAll   <= blankAll; // RULE9
            firstBiasVdd  <= upperIo;  // RULE7
            secondBiasLcd <= ~lowerIo; // RULE8
        end
    end

endmodule

// ===== rtl/gpio_port_lcd_share_defines.vh
// Purpose: register offsets, field positions and reset values of the gpio/lcd share block
// Assumes: byte-wide registers, printed offsets are word indices (byte address = 4 * index)
// Notes:   definitions only
`ifndef GPIO_PORT_LCD_SHARE_DEFINES_VH
`define GPIO_PORT_LCD_SHARE_DEFINES_VH

// register indices
`define IDX_LCD_CTRL      8'h89
`define IDX_P1_DIR        8'hC1
`define IDX_P2_DIR        8'hC2
`define IDX_P5_DIR        8'hC5
`define IDX_P0_DATA       8'hD0
`define IDX_P1_DATA       8'hD1
`define IDX_P2_DATA       8'hD2
`define IDX_P5_DATA       8'hD5
`define IDX_P0_PULLUP     8'hE0
`define IDX_P1_PULLUP     8'hE1
`define IDX_P2_PULLUP     8'hE2
`define IDX_P5_PULLUP     8'hE5
// bit-set / bit-clear helper: index of the register, written value = {set, dir, 3-bit port, 3-bit bitnum}
`define IDX_BIT_OP        8'hF0
`define BITOP_SET         8'h80
`define BITOP_DIR         8'h40
`define BITOP_PORT_LSB    3
`define BITOP_BIT_LSB     0

// lcd control fields
`define LCD_LOWER_SEL_BIT 0
`define LCD_UPPER_SEL_BIT 1
`define LCD_ENABLE_BIT    3
`define LCD_BLANK_BIT     5
`define LCD_CTRL_MASK     8'h2B

// reset values
`define RST_BYTE          8'h00
`define P0_MASK           8'h03

`endif

// ===== tb/gpio_lcd_checker.sv
// Purpose: bus and pin checks of the gpio/lcd share block
// Assumes: bound to the top module; a write counts only with byte lane 0 enabled
// Notes:   a write shows at the pins two edges after it is taken
`timescale 1ns/1ps
module gpio_lcd_checker (
    input logic        clk,          // clock
    input logic        rst_b,        // reset, low
    input logic        wb_cyc_i,     // cycle
    input logic        wb_stb_i,     // strobe
    input logic        wb_we_i,      // write
    input logic [3:0]  wb_sel_i,     // byte lanes
    input logic [9:0]  wb_adr_i,     // address
    input logic [31:0] wb_dat_i,     // write data
    input logic [31:0] wb_dat_o,     // read data
    input logic        wb_ack_o,     // ack
    input logic [7:0]  p1Oe,         // port 1 enables
    input logic [7:0]  p2Oe,         // port 2 enables
    input logic [7:0]  lcdSegEn,     // segment enables
    input logic        lcdDriverOn,  // lcd on
    input logic        lcdBlankAll,  // blank
    input logic        firstBiasVdd, // bias 1
    input logic        secondBiasLcd // bias 2
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // a request is new only while ack is low
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wr  = req && wb_we_i && wb_sel_i[0];
    a_ack_next: assert property (req |=> wb_ack_o) else $error("request not acked");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    a_data_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("stale data");
    a_upper_group: assert property (lcdSegEn[3:0] == {4{!firstBiasVdd}}
        && (p2Oe[3:0] & lcdSegEn[3:0]) == 4'h0) else $error("upper group mixed");
    a_lower_group: assert property (lcdSegEn[7:4] == {4{secondBiasLcd}}
        && (p2Oe[7:4] & lcdSegEn[7:4]) == 4'h0) else $error("lower group mixed");
    a_dir_apply: assert property (wr && wb_adr_i == 10'h304
        |=> ##1 p1Oe == $past(wb_dat_i[7:0], 2)) else $error("direction not applied");
    a_ctrl_apply: assert property (wr && wb_adr_i == 10'h224 |=> ##1
        {lcdDriverOn, lcdBlankAll} == $past({wb_dat_i[3], wb_dat_i[5]}, 2)) else $error("lcd ctrl");
    a_pull_hidden: assert property (req && !wb_we_i && wb_adr_i[9:4] == 6'h38
        |=> wb_dat_o == 32'h0) else $error("pull-up readable");
    c_ctrl_write: cover property (wr && wb_adr_i == 10'h224);
    c_upper_io: cover property (|p2Oe[3:0]);
    c_lower_io: cover property (|p2Oe[7:4]);
endmodule
bind gpio_port_lcd_share gpio_lcd_checker chk (.*);

// ===== tb/pin_board.sv
// Purpose: pin levels seen by the block
// Assumes: ext is the board level on released pins
// Notes:   a released pin never keeps the last driven value
`timescale 1ns/1ps
module pin_board #(parameter int W = 8) (
    input  logic [W-1:0] drv,  // block drive
    input  logic [W-1:0] oe,   // block enable
    input  logic [W-1:0] pull, // pull-ups
    input  logic [W-1:0] ext,  // board level
    output logic [W-1:0] lvl   // pin level
);
    // block drive wins, then pull-up, then the board
    assign lvl = (oe & drv) | (~oe & (pull | ext));
endmodule

// ===== tb/tb_gpio_port_lcd_share.sv
// Purpose: random and corner checks of the gpio/lcd share block
// Assumes: seed 16, board levels random per round
// Notes:   port 0 is input only: pull-ups and pin reads are checked
`timescale 1ns/1ps
module tb_gpio_port_lcd_share;
    logic        clk = 0, rst_b = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
    logic [9:0]  wb_adr_i = 0;
    logic [3:0]  wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 0, wb_dat_o, ext = 0;
    logic [1:0]  p0In, p0PullEn;
    logic [7:0]  p1In, p2In, p5In, p1Out, p1Oe, p2Out, p2Oe, p5Out, p5Oe, lcdSegEn;
    logic [7:0]  p1PullEn, p2PullEn, p5PullEn, q, c, g, o, d[3], m[3], u[3];
    logic [7:0]  pn[3] = '{8'h01, 8'h02, 8'h05};
    logic        lcdDriverOn, lcdBlankAll, firstBiasVdd, secondBiasLcd, s, y;
    int          fail_count = 0, compares = 0, cycles = 0, r, b;
    gpio_port_lcd_share dut (.clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .p0In, .p1In, .p2In, .p5In, .p1Out,
        .p1Oe, .p2Out, .p2Oe, .p5Out, .p5Oe, .p0PullEn, .p1PullEn, .p2PullEn, .p5PullEn,
        .lcdSegEn, .lcdDriverOn, .lcdBlankAll, .firstBiasVdd, .secondBiasLcd);
    // board side of every port; port 0 is never driven by the block
    pin_board #(.W(2)) b0 (.drv(2'h0), .oe(2'h0), .pull(p0PullEn), .ext(ext[25:24]), .lvl(p0In));
    pin_board b1 (.drv(p1Out), .oe(p1Oe), .pull(p1PullEn), .ext(ext[7:0]), .lvl(p1In));
    pin_board b2 (.drv(p2Out), .oe(p2Oe), .pull(p2PullEn), .ext(ext[15:8]), .lvl(p2In));
    pin_board b5 (.drv(p5Out), .oe(p5Oe), .pull(p5PullEn), .ext(ext[23:16]), .lvl(p5In));
    always #2 clk = ~clk;
    // hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            final_report();
        end
    end
    task automatic chk(input logic [31:0] got, exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one classic cycle, held until ack is sampled
    task automatic bus(input logic w, input logic [7:0] i, v);
        wb_cyc_i <= 1;
        wb_stb_i <= 1;
        wb_we_i <= w;
        wb_adr_i <= {i, 2'b00};
        wb_dat_i <= {24'h0, v};
        do @(posedge clk); while (wb_ack_o !== 1'b1);
        q = wb_dat_o[7:0];
        wb_cyc_i <= 0;
        wb_stb_i <= 0;
        @(posedge clk);
    endtask
    function automatic logic [7:0] exp_pin(input logic [7:0] oe, dv, pu, e);
        return (oe & dv) | (~oe & (pu | e));
    endfunction
    task automatic reset_check();
        rst_b <= 0;
        repeat (2) @(posedge clk);
        rst_b <= 1;
        @(posedge clk);
        chk({p1Oe, p2Oe, p5Oe, p0PullEn}, 0);
        chk({p1PullEn, p2PullEn, p5PullEn}, 0);
        chk({lcdSegEn, lcdDriverOn, lcdBlankAll, firstBiasVdd, secondBiasLcd}, 12'hFF1);
    endtask
    task automatic final_report();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        void'($urandom(16));
        reset_check();
        // unmapped index drops writes and reads zero
        bus(1, 8'h10, 8'hFF);
        bus(0, 8'h10, 8'h00);
        chk(q, 0);
        // a write with byte lane 0 off is acked and dropped
        wb_sel_i <= 4'hE;
        bus(1, 8'hC1, 8'hFF);
        wb_sel_i <= 4'hF;
        bus(0, 8'hC1, 8'h00);
        chk(q, 0);
        for (int t = 0; t < 40; t++) begin
            c = 8'($urandom) & 8'h2B;
            g = {{4{c[0]}}, {4{c[1]}}};
            ext <= $urandom;
            bus(1, 8'h89, c);
            foreach (pn[k]) begin
                d[k] = 8'($urandom);
                m[k] = 8'($urandom);
                u[k] = 8'($urandom);
                bus(1, 8'hD0 | pn[k], d[k]);
                bus(1, 8'hC0 | pn[k], m[k]);
                bus(1, 8'hE0 | pn[k], u[k]);
            end
            // one single-bit operation on a random port
            r = $urandom % 3;
            b = $urandom % 8;
            {s, y} = 2'($urandom);
            bus(1, 8'hF0, {s, y, pn[r][2:0], 3'(b)});
            if (y) m[r][b] = s;
            else d[r][b] = s;
            chk({p1Oe, p2Oe, p5Oe}, {m[0], m[1] & g, m[2]});
            chk({p1Out, p2Out, p5Out}, {d[0], d[1], d[2]});
            chk({p1PullEn, p2PullEn, p5PullEn}, {u[0], u[1], u[2]});
            chk({lcdSegEn[3:0], firstBiasVdd}, {~g[3:0], c[1]});
            chk({lcdSegEn[7:4], secondBiasLcd}, {~g[7:4], ~c[0]});
            chk(lcdBlankAll, c[5]);
            chk(lcdDriverOn, c[3]);
            // port 0: pull-ups and the read path of the input-only pins
            o = 8'($urandom) & 8'h03;
            bus(1, 8'hE0, o);
            chk(p0PullEn, o[1:0]);
            bus(0, 8'hD0, 8'h00);
            chk(q, o | {6'h00, ext[25:24]});
            foreach (pn[k]) begin
                bus(0, 8'hD0 | pn[k], 8'h00);
                chk(q, exp_pin(m[k] & (k == 1 ? g : 8'hFF), d[k], u[k], ext[8*k+:8]));
                bus(0, 8'hE0 | pn[k], 8'h00);
                chk(q, 0);
                bus(0, 8'hC0 | pn[k], 8'h00);
                chk(q, m[k]);
            end
        end
        reset_check();
        final_report();
    end
endmodule
